// *** pkg/meas_ctrl_pkg.sv ***
// Purpose: shared constants and types for the measurement control block
// Assumes: system clock of 25 MHz
// Notes: register images are 8 bits; both control registers reset to zero
package meas_ctrl_pkg;

   // ==========================================
   // register map
   localparam logic [7:0] ADDR_MEAS_CTRL = 8'h10;
   localparam logic [7:0] ADDR_CORR_CTRL = 8'h11;
   localparam logic [7:0] ADDR_X_LOW = 8'h02;
   localparam logic [7:0] ADDR_Y_LOW = 8'h04;
   localparam logic [7:0] ADDR_Z_LOW = 8'h06;
   localparam logic [7:0] MEAS_CTRL_RESET = 8'h00;
   localparam logic [7:0] CORR_CTRL_RESET = 8'h00;

   // ==========================================
   // field positions
   localparam int RATE_MSB = 7;
   localparam int RATE_LSB = 5;
   localparam int AVG_MSB = 4;
   localparam int AVG_LSB = 3;
   localparam int SKIP_BIT = 2;
   localparam int TRIG_BIT = 1;
   localparam int RUN_BIT = 0;
   localparam int AUTO_RST_BIT = 7;
   localparam int BYPASS_BIT = 5;
   localparam int SRESET_BIT = 4;

   // ==========================================
   // timing
   localparam int SYS_CLK_HZ = 25_000_000;
   localparam int SYS_CLK_NS = 40;
   localparam int CONV_FAST_HZ = 1280;
   localparam int CONV_FAST_CYCLES = SYS_CLK_HZ / CONV_FAST_HZ;
   localparam int SRESET_TIME_NS = 1000;
   localparam int SRESET_CYCLES = (SRESET_TIME_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
   localparam int AVG_LOG2_BASE = 4;
   localparam logic [2:0] RATE_SLOW_CODE = 3'h4;

   typedef enum logic [1:0] {ST_IDLE, ST_SRESET, ST_ACQ, ST_GAP} meas_state_t;

   // auto-increment, optionally stepping over the low data bytes
   function automatic logic [7:0] next_burst_addr(input logic [7:0] a, input logic skip);
      logic [7:0] n;
      n = a + 8'h01;
      if (skip && (n == ADDR_X_LOW || n == ADDR_Y_LOW || n == ADDR_Z_LOW)) begin
         n = n + 8'h01;
      end
      return n;
   endfunction : next_burst_addr

endpackage : meas_ctrl_pkg

// *** pkg/link_xfer_if.sv ***
// Purpose: crossing signals between link-side port and measurement core
// Assumes: toggle handshakes, data held stable until acknowledged
// Notes: link_end runs on the link clock, core_end on the system clock
`timescale 1ns/1ps
`default_nettype none
interface link_xfer_if;
   logic wr_tgl;
   logic [7:0] wr_addr;
   logic [7:0] wr_data;
   logic wr_ack_tgl;
   logic img_tgl;
   logic [15:0] img;
   logic img_ack_tgl;

   modport link_end(output wr_tgl, output wr_addr, output wr_data, output img_ack_tgl,
                    input wr_ack_tgl, input img_tgl, input img);
   modport core_end(input wr_tgl, input wr_addr, input wr_data, input img_ack_tgl,
                    output wr_ack_tgl, output img_tgl, output img);
endinterface : link_xfer_if
`default_nettype wire

// *** verilog/reg_link_port.sv ***
// Purpose: link-clock register port: write capture, read mux, burst address
// Assumes: the serial engine presents one byte access per strobe
// Notes: one write in flight; further writes wait for wr_ready
`timescale 1ns/1ps
`default_nettype none
module reg_link_port (
   input wire logic clk_link_i,
   input wire logic rst_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_wr_ready_o,
   output logic [7:0] burst_next_addr_o,
   output logic burst_skip_low_bytes_o,
   link_xfer_if.link_end xf
);
   typedef struct packed {
      logic rst_s1;
      logic rst_s2;
      logic wack_s1;
      logic wack_s2;
      logic img_s1;
      logic img_s2;
      logic wr_tgl;
      logic wr_busy;
      logic wr_ready;
      logic [7:0] wr_addr;
      logic [7:0] wr_data;
      logic img_ack;
      logic [15:0] img;
      logic [7:0] rdata;
      logic [7:0] next_addr;
   } link_state_t;

   link_state_t s_ff;
   link_state_t nxt_s;

   // ==========================================
   // next state
   always_comb begin
      nxt_s = s_ff;
      nxt_s.rst_s1 = rst_i;
      nxt_s.rst_s2 = s_ff.rst_s1;
      nxt_s.wack_s1 = xf.wr_ack_tgl;
      nxt_s.wack_s2 = s_ff.wack_s1;
      nxt_s.img_s1 = xf.img_tgl;
      nxt_s.img_s2 = s_ff.img_s1;
      if (s_ff.wr_busy && s_ff.wack_s2 == s_ff.wr_tgl) begin
         nxt_s.wr_busy = 1'b0;
      end
      if (reg_wr_i && s_ff.wr_ready) begin
         nxt_s.wr_addr = reg_addr_i;
         nxt_s.wr_data = reg_wdata_i;
         nxt_s.wr_tgl = ~s_ff.wr_tgl;
         nxt_s.wr_busy = 1'b1;
      end
      nxt_s.wr_ready = ~nxt_s.wr_busy;
      // image is held stable by the core until this ack is seen
      if (s_ff.img_s2 != s_ff.img_ack) begin
         nxt_s.img = xf.img;
         nxt_s.img_ack = s_ff.img_s2;
      end
      if (reg_rd_i) begin
         case (reg_addr_i)
            meas_ctrl_pkg::ADDR_MEAS_CTRL: nxt_s.rdata = s_ff.img[7:0];
            meas_ctrl_pkg::ADDR_CORR_CTRL: nxt_s.rdata = s_ff.img[15:8];
            default: nxt_s.rdata = 8'h00;
         endcase
         // RQ8 full byte pairs
         // RQ9 skip low bytes
         nxt_s.next_addr = meas_ctrl_pkg::next_burst_addr(reg_addr_i,
                                                          s_ff.img[meas_ctrl_pkg::SKIP_BIT]);
      end
      if (s_ff.rst_s2) begin
         nxt_s.wack_s1 = 1'b0;
         nxt_s.wack_s2 = 1'b0;
         nxt_s.img_s1 = 1'b0;
         nxt_s.img_s2 = 1'b0;
         nxt_s.wr_tgl = 1'b0;
         nxt_s.wr_busy = 1'b0;
         nxt_s.wr_ready = 1'b0;
         nxt_s.wr_addr = 8'h00;
         nxt_s.wr_data = 8'h00;
         nxt_s.img_ack = 1'b0;
         nxt_s.img = {meas_ctrl_pkg::CORR_CTRL_RESET, meas_ctrl_pkg::MEAS_CTRL_RESET};
         nxt_s.rdata = 8'h00;
         nxt_s.next_addr = 8'h00;
      end
   end

   always_ff @(posedge clk_link_i) begin
      s_ff <= nxt_s;
   end

   assign reg_rdata_o = s_ff.rdata;
   assign reg_wr_ready_o = s_ff.wr_ready;
   assign burst_next_addr_o = s_ff.next_addr;
   assign burst_skip_low_bytes_o = s_ff.img[meas_ctrl_pkg::SKIP_BIT];
   assign xf.wr_tgl = s_ff.wr_tgl;
   assign xf.wr_addr = s_ff.wr_addr;
   assign xf.wr_data = s_ff.wr_data;
   assign xf.img_ack_tgl = s_ff.img_ack;

endmodule : reg_link_port
`default_nettype wire

// *** verilog/magnetometer_measurement_control.sv ***
// Purpose: measurement control of a three-axis magnetometer
// Assumes: converter samples arrive on the system clock with adc_valid_i
// Notes: registers are written and read on the link clock
// Operation
// RQ1 - host edits rate fields only in standby; the code takes rate writes in any state, measuring or not
// RQ2 - rate code bits 7:5, reset 000
// RQ3 - averaging code bits 4:3, 16 to 128
// RQ4 - accumulate and average before output
// RQ5 - averaging applies to triggered and periodic
// RQ6 - converter rate set by rate code
// RQ7 - output rate divides further above code 100
// RQ8 - fast-read clear gives full 16-bit bursts
// RQ9 - fast-read set skips low bytes
// RQ10 - trigger bit requests one measurement
// RQ11 - trigger when active runs at fastest rate
// RQ12 - trigger in standby measures once, returns
// RQ13 - run bit selects standby or periodic
// RQ14 - bypass bit suppresses offset subtraction
// RQ15 - sensor reset bit busy then self-clears
// RQ16 - auto sensor reset before each acquisition
// RQ17 - auto reset enable reads as zero
// RQ18 - trigger clears after its result lands
`timescale 1ns/1ps
`default_nettype none
module magnetometer_measurement_control #(
   parameter int unsigned CONV_FAST_CYCLES = meas_ctrl_pkg::CONV_FAST_CYCLES
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic clk_link_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_wr_ready_o,
   output logic [7:0] burst_next_addr_o,
   output logic burst_skip_low_bytes_o,
   input wire logic adc_valid_i,
   input wire logic [15:0] adc_x_i,
   input wire logic [15:0] adc_y_i,
   input wire logic [15:0] adc_z_i,
   input wire logic [15:0] off_x_i,
   input wire logic [15:0] off_y_i,
   input wire logic [15:0] off_z_i,
   output logic conv_start_o,
   output logic sensor_reset_o,
   output logic result_valid_o,
   output logic [15:0] result_x_o,
   output logic [15:0] result_y_o,
   output logic [15:0] result_z_o
);
   // period shifts by up to 4, so the base must fit 16 bits
   if (CONV_FAST_CYCLES < 1 || CONV_FAST_CYCLES > 65535) begin : g_bad_period
      $error("CONV_FAST_CYCLES out of range");
   end

   typedef struct packed {
      logic wreq_s1;
      logic wreq_s2;
      logic wack;
      logic iack_s1;
      logic iack_s2;
      logic img_tgl;
      logic img_busy;
      logic [15:0] img;
      logic [2:0] rate;
      logic [1:0] avg;
      logic skip;
      logic trig;
      logic run;
      logic auto_rst;
      logic bypass;
      logic [7:0] sres_cnt;
      logic sres_out;
      meas_ctrl_pkg::meas_state_t state;
      logic fast;
      logic [19:0] conv_cnt;
      logic conv_start;
      logic [7:0] samp_cnt;
      logic [9:0] gap_cnt;
      logic [22:0] acc_x;
      logic [22:0] acc_y;
      logic [22:0] acc_z;
      logic [15:0] res_x;
      logic [15:0] res_y;
      logic [15:0] res_z;
      logic res_valid;
   } core_state_t;

   core_state_t s_ff;
   core_state_t nxt_s;
   logic [7:0] n_avg;
   logic [19:0] period;
   logic [9:0] gap_len;
   logic [15:0] cur_img;
   logic wr_hit;
   logic acq_start;
   logic last_samp;

   link_xfer_if xf();

   reg_link_port u_link (
      .clk_link_i(clk_link_i),
      .rst_i(rst_i),
      .reg_addr_i(reg_addr_i),
      .reg_wr_i(reg_wr_i),
      .reg_wdata_i(reg_wdata_i),
      .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o),
      .reg_wr_ready_o(reg_wr_ready_o),
      .burst_next_addr_o(burst_next_addr_o),
      .burst_skip_low_bytes_o(burst_skip_low_bytes_o),
      .xf(xf.link_end)
   );

   // ==========================================
   // helpers
   function automatic logic [22:0] sext(input logic [15:0] v);
      return {{7{v[15]}}, v};
   endfunction : sext

   // average an accumulated sum and apply the user offset
   function automatic logic [15:0] avg_axis(input logic [22:0] sum, input logic [1:0] avg,
                                            input logic [15:0] off, input logic bypass);
      logic signed [22:0] q;
      logic signed [16:0] r;
      q = $signed(sum) >>> (meas_ctrl_pkg::AVG_LOG2_BASE + int'(avg));
      r = $signed(q[16:0]);
      // RQ14 offset subtraction
      if (!bypass) begin
         r = r - $signed({off[15], off});
      end
      return r[15:0];
   endfunction : avg_axis

   // ==========================================
   // derived settings
   always_comb begin
      // RQ3 samples per result
      n_avg = 8'h10 << s_ff.avg;
      // RQ6 converter rate
      // RQ11 fastest rate on trigger
      if (s_ff.fast) begin
         period = 20'(CONV_FAST_CYCLES);
      end else if (s_ff.rate >= meas_ctrl_pkg::RATE_SLOW_CODE) begin
         period = 20'(CONV_FAST_CYCLES) << 4;
      end else begin
         period = 20'(CONV_FAST_CYCLES) << s_ff.rate;
      end
      // RQ7 idle conversions between results
      if (s_ff.rate > meas_ctrl_pkg::RATE_SLOW_CODE) begin
         gap_len = 10'(n_avg) * ((10'h001 << (s_ff.rate - meas_ctrl_pkg::RATE_SLOW_CODE))
                                 - 10'h001);
      end else begin
         gap_len = 10'h000;
      end
      cur_img = {1'b0, 1'b0, s_ff.bypass, s_ff.sres_out, 4'h0,
                 s_ff.rate, s_ff.avg, s_ff.skip, s_ff.trig, s_ff.run};
      wr_hit = s_ff.wreq_s2 != s_ff.wack;
      last_samp = adc_valid_i && (s_ff.samp_cnt + 8'h01 == n_avg);
   end

   // ==========================================
   // next state
   always_comb begin
      nxt_s = s_ff;
      nxt_s.conv_start = 1'b0;
      nxt_s.res_valid = 1'b0;
      acq_start = 1'b0;
      nxt_s.wreq_s1 = xf.wr_tgl;
      nxt_s.wreq_s2 = s_ff.wreq_s1;
      nxt_s.iack_s1 = xf.img_ack_tgl;
      nxt_s.iack_s2 = s_ff.iack_s1;

      if (s_ff.sres_cnt != 8'h00) begin
         nxt_s.sres_cnt = s_ff.sres_cnt - 8'h01;
      end

      // register writes, data held stable by the link side
      if (wr_hit) begin
         nxt_s.wack = s_ff.wreq_s2;
         if (xf.wr_addr == meas_ctrl_pkg::ADDR_MEAS_CTRL) begin
            // RQ2 rate field
            nxt_s.rate = xf.wr_data[meas_ctrl_pkg::RATE_MSB:meas_ctrl_pkg::RATE_LSB];
            nxt_s.avg = xf.wr_data[meas_ctrl_pkg::AVG_MSB:meas_ctrl_pkg::AVG_LSB];
            nxt_s.skip = xf.wr_data[meas_ctrl_pkg::SKIP_BIT];
            // RQ13 run select
            nxt_s.run = xf.wr_data[meas_ctrl_pkg::RUN_BIT];
         end
         if (xf.wr_addr == meas_ctrl_pkg::ADDR_CORR_CTRL) begin
            nxt_s.auto_rst = xf.wr_data[meas_ctrl_pkg::AUTO_RST_BIT];
            nxt_s.bypass = xf.wr_data[meas_ctrl_pkg::BYPASS_BIT];
            // RQ15 start reset cycle
            if (xf.wr_data[meas_ctrl_pkg::SRESET_BIT] && s_ff.sres_cnt == 8'h00) begin
               nxt_s.sres_cnt = 8'(meas_ctrl_pkg::SRESET_CYCLES);
            end
         end
      end

      // conversion pacing while measuring
      if (s_ff.state == meas_ctrl_pkg::ST_ACQ || s_ff.state == meas_ctrl_pkg::ST_GAP) begin
         if (s_ff.conv_cnt <= 20'h00001) begin
            nxt_s.conv_cnt = period;
         end else begin
            nxt_s.conv_cnt = s_ff.conv_cnt - 20'h00001;
         end
         if (s_ff.trig && s_ff.run) begin
            nxt_s.fast = 1'b1;
         end
      end

      case (s_ff.state)
         meas_ctrl_pkg::ST_IDLE: begin
            nxt_s.fast = 1'b0;
            // RQ10 measure on run or trigger
            // RQ12 standby trigger
            if (s_ff.run || s_ff.trig) begin
               // RQ16 auto reset first
               if (s_ff.auto_rst) begin
                  nxt_s.state = meas_ctrl_pkg::ST_SRESET;
                  nxt_s.sres_cnt = 8'(meas_ctrl_pkg::SRESET_CYCLES);
               end else begin
                  acq_start = 1'b1;
               end
            end
         end
         meas_ctrl_pkg::ST_SRESET: begin
            if (s_ff.sres_cnt == 8'h00) begin
               acq_start = 1'b1;
            end
         end
         meas_ctrl_pkg::ST_ACQ: begin
            if (!s_ff.run && !s_ff.trig) begin
               nxt_s.state = meas_ctrl_pkg::ST_IDLE;
            end else begin
               if (s_ff.conv_cnt <= 20'h00001) begin
                  nxt_s.conv_start = 1'b1;
               end
               // RQ4 accumulate samples
               // RQ5 same count for both
               if (adc_valid_i) begin
                  nxt_s.acc_x = s_ff.acc_x + sext(adc_x_i);
                  nxt_s.acc_y = s_ff.acc_y + sext(adc_y_i);
                  nxt_s.acc_z = s_ff.acc_z + sext(adc_z_i);
                  nxt_s.samp_cnt = s_ff.samp_cnt + 8'h01;
               end
               if (last_samp) begin
                  nxt_s.res_x = avg_axis(nxt_s.acc_x, s_ff.avg, off_x_i, s_ff.bypass);
                  nxt_s.res_y = avg_axis(nxt_s.acc_y, s_ff.avg, off_y_i, s_ff.bypass);
                  nxt_s.res_z = avg_axis(nxt_s.acc_z, s_ff.avg, off_z_i, s_ff.bypass);
                  nxt_s.res_valid = 1'b1;
                  nxt_s.fast = 1'b0;
                  // RQ18 trigger self-clear
                  nxt_s.trig = 1'b0;
                  if (s_ff.run && !s_ff.trig && gap_len != 10'h000) begin
                     nxt_s.state = meas_ctrl_pkg::ST_GAP;
                     nxt_s.gap_cnt = gap_len;
                  end else begin
                     nxt_s.state = meas_ctrl_pkg::ST_IDLE;
                  end
               end
            end
         end
         meas_ctrl_pkg::ST_GAP: begin
            // a trigger cuts the idle stretch short
            if (!s_ff.run || s_ff.trig) begin
               nxt_s.state = meas_ctrl_pkg::ST_IDLE;
            end else if (s_ff.conv_cnt <= 20'h00001) begin
               nxt_s.gap_cnt = s_ff.gap_cnt - 10'h001;
               if (s_ff.gap_cnt == 10'h001) begin
                  nxt_s.state = meas_ctrl_pkg::ST_IDLE;
               end
            end
         end
         default: nxt_s.state = meas_ctrl_pkg::ST_IDLE;
      endcase

      if (acq_start) begin
         nxt_s.state = meas_ctrl_pkg::ST_ACQ;
         nxt_s.acc_x = 23'h000000;
         nxt_s.acc_y = 23'h000000;
         nxt_s.acc_z = 23'h000000;
         nxt_s.samp_cnt = 8'h00;
         nxt_s.conv_cnt = 20'h00001;
      end

      // a trigger written now wins over the completion clear
      if (wr_hit && xf.wr_addr == meas_ctrl_pkg::ADDR_MEAS_CTRL
          && xf.wr_data[meas_ctrl_pkg::TRIG_BIT]) begin
         nxt_s.trig = 1'b1;
      end

      // RQ15 busy flag
      nxt_s.sres_out = nxt_s.sres_cnt != 8'h00;

      // RQ17 auto enable left out of image
      if (s_ff.img_busy && s_ff.iack_s2 == s_ff.img_tgl) begin
         nxt_s.img_busy = 1'b0;
      end
      if (!s_ff.img_busy && cur_img != s_ff.img) begin
         nxt_s.img = cur_img;
         nxt_s.img_tgl = ~s_ff.img_tgl;
         nxt_s.img_busy = 1'b1;
      end

      if (rst_i) begin
         nxt_s = '0;
         nxt_s.state = meas_ctrl_pkg::ST_IDLE;
         nxt_s.img = {meas_ctrl_pkg::CORR_CTRL_RESET, meas_ctrl_pkg::MEAS_CTRL_RESET};
      end
   end

   always_ff @(posedge clk_sys_i) begin
      s_ff <= nxt_s;
   end

   assign xf.wr_ack_tgl = s_ff.wack;
   assign xf.img_tgl = s_ff.img_tgl;
   assign xf.img = s_ff.img;
   assign conv_start_o = s_ff.conv_start;
   assign sensor_reset_o = s_ff.sres_out;
   assign result_valid_o = s_ff.res_valid;
   assign result_x_o = s_ff.res_x;
   assign result_y_o = s_ff.res_y;
   assign result_z_o = s_ff.res_z;

endmodule : magnetometer_measurement_control
`default_nettype wire

// *** test/meas_ctrl_props.sv ***
// Purpose: port checks for the measurement control block
// Assumes: rst_i high resets both clock domains
// Notes: bound onto the top module
`timescale 1ns/1ps
`default_nettype none
module meas_ctrl_props #(
   parameter int unsigned CONV_FAST_CYCLES = 8
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic clk_link_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic reg_wr_ready_o,
   input wire logic [7:0] burst_next_addr_o,
   input wire logic burst_skip_low_bytes_o,
   input wire logic conv_start_o,
   input wire logic sensor_reset_o,
   input wire logic result_valid_o,
   input wire logic [15:0] result_x_o
);
   // ==========================================
   // sensor reset length
   logic [7:0] busy_cnt_ff;
   logic [7:0] nxt_busy_cnt;
   always_comb nxt_busy_cnt = sensor_reset_o ? busy_cnt_ff + 8'h01 : 8'h00;
   always_ff @(posedge clk_sys_i) busy_cnt_ff <= rst_i ? 8'h00 : nxt_busy_cnt;

   function automatic logic [7:0] step(input logic [7:0] a, input logic s);
      logic [7:0] n;
      n = a + 8'h01;
      return (s && (n == 8'h02 || n == 8'h04 || n == 8'h06)) ? n + 8'h01 : n;
   endfunction : step

   // ==========================================
   // assertions
   a_result_one_cycle: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      result_valid_o |=> !result_valid_o) else $error("result pulse too long");
   a_result_held_between: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      $changed(result_x_o) |-> result_valid_o) else $error("result moved alone");
   a_conv_single_pulse: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      conv_start_o |=> !conv_start_o) else $error("conversion pulse too long");
   a_sreset_exact_length: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      $fell(sensor_reset_o) |-> busy_cnt_ff == meas_ctrl_pkg::SRESET_CYCLES)
      else $error("sensor reset length wrong");
   a_wr_ready_drops: assert property (@(posedge clk_link_i) disable iff (rst_i)
      reg_wr_i && reg_wr_ready_o |=> !reg_wr_ready_o) else $error("ready held");
   a_wr_ready_returns: assert property (@(posedge clk_link_i) disable iff (rst_i)
      $fell(reg_wr_ready_o) |-> ##[1:24] reg_wr_ready_o) else $error("ready stuck");
   a_burst_addr_step: assert property (@(posedge clk_link_i) disable iff (rst_i)
      reg_rd_i |=> burst_next_addr_o == step($past(reg_addr_i), $past(burst_skip_low_bytes_o)))
      else $error("burst address wrong");
   a_unmapped_read_zero: assert property (@(posedge clk_link_i) disable iff (rst_i)
      reg_rd_i && reg_addr_i == 8'h20 |=> reg_rdata_o == 8'h00) else $error("unmapped read");
endmodule : meas_ctrl_props
bind magnetometer_measurement_control meas_ctrl_props #(
   .CONV_FAST_CYCLES(CONV_FAST_CYCLES)
) u_props (.clk_sys_i, .rst_i, .clk_link_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
   .reg_wr_ready_o, .burst_next_addr_o, .burst_skip_low_bytes_o, .conv_start_o,
   .sensor_reset_o, .result_valid_o, .result_x_o);
`default_nettype wire

// *** test/host_link_model.sv ***
// Purpose: host side of the register port
// Assumes: link clock runs free
// Notes: released lines carry the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
   input wire logic clk_link_i,
   input wire logic reg_wr_ready_i,
   output logic [7:0] reg_addr_o,
   output logic reg_wr_o,
   output logic [7:0] reg_wdata_o,
   output logic reg_rd_o
);
   initial begin
      reg_addr_o = 8'h00;
      reg_wr_o = 1'b0;
      reg_wdata_o = 8'h00;
      reg_rd_o = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
      int n;
      ok = 1'b0;
      for (n = 0; n < 64 && !ok; n++) begin
         @(posedge clk_link_i);
         ok = reg_wr_ready_i;
      end
      if (ok) begin
         reg_addr_o <= a;
         reg_wdata_o <= d;
         reg_wr_o <= 1'b1;
         @(posedge clk_link_i);
         reg_wr_o <= 1'b0;
         reg_wdata_o <= ~d;
         reg_addr_o <= ~a;
         ok = 1'b0;
         for (n = 0; n < 64 && !ok; n++) begin
            @(posedge clk_link_i);
            ok = reg_wr_ready_i;
         end
      end
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge clk_link_i);
      reg_addr_o <= a;
      reg_rd_o <= 1'b1;
      @(posedge clk_link_i);
      reg_rd_o <= 1'b0;
      reg_addr_o <= ~a;
   endtask : rd
endmodule : host_link_model
`default_nettype wire

// *** test/magnetometer_measurement_control_tb.sv ***
// Purpose: self-checking bench for measurement control
// Assumes: short conversion period of 8 system cycles
// Notes: converter answers each conversion request one cycle later
`timescale 1ns/1ps
`default_nettype none
module magnetometer_measurement_control_tb;
   localparam int CF = 8;
   logic clk_sys_i = 1'b0, clk_link_i = 1'b0, rst_i = 1'b1;
   logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, burst_next_addr_o;
   logic reg_wr_i, reg_rd_i, reg_wr_ready_o, burst_skip_low_bytes_o;
   logic adc_valid_i = 1'b0, conv_start_o, sensor_reset_o, result_valid_o;
   logic [15:0] adc_x_i = 16'h0, adc_y_i = 16'h0, adc_z_i = 16'h0;
   logic [15:0] off_x_i = 16'h0, off_y_i = 16'h0, off_z_i = 16'h0;
   logic [15:0] result_x_o, result_y_o, result_z_o, rnd = 16'hFEFC;
   logic [47:0] exp_q[$];
   logic [7:0] rd_q[$];
   logic [1:0] avg = 2'h0;
   logic byp = 1'b0, aut = 1'b0, rst_seen = 1'b0, rd_seen = 1'b0;
   int err_count = 0, cmp_count = 0, conv_n = 0, res_n = 0, cnt = 0;
   int cyc = 0, last = 0, period = 0, sx = 0, sy = 0, sz = 0;

   always #20 clk_sys_i = ~clk_sys_i;
   always #15 clk_link_i = ~clk_link_i;

   magnetometer_measurement_control #(.CONV_FAST_CYCLES(CF)) u_magnetometer_measurement_control (
      .clk_sys_i, .rst_i, .clk_link_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i,
      .reg_rdata_o, .reg_wr_ready_o, .burst_next_addr_o, .burst_skip_low_bytes_o, .adc_valid_i,
      .adc_x_i, .adc_y_i, .adc_z_i, .off_x_i, .off_y_i, .off_z_i, .conv_start_o,
      .sensor_reset_o, .result_valid_o, .result_x_o, .result_y_o, .result_z_o);
   host_link_model u_host (.clk_link_i, .reg_wr_ready_i(reg_wr_ready_o), .reg_addr_o(reg_addr_i),
      .reg_wr_o(reg_wr_i), .reg_wdata_o(reg_wdata_i), .reg_rd_o(reg_rd_i));

   // ==========================================
   // helpers
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   function automatic logic [15:0] res16(input int s, input logic [15:0] o);
      return 16'((s >>> (4 + avg)) - (byp ? 0 : int'($signed(o))));
   endfunction : res16
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp);
      end
   endtask : chk
   task automatic summarize;
      if (err_count == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : summarize
   task automatic wrx(input logic [7:0] a, input logic [7:0] d);
      logic ok;
      u_host.wr(a, d, ok);
      if (!ok) begin
         err_count++;
         summarize();
      end
      repeat (6) @(posedge clk_link_i);
   endtask : wrx
   task automatic rdx(input logic [7:0] a, input logic [7:0] e);
      rd_q.push_back(e);
      u_host.rd(a);
   endtask : rdx
   // bounded wait for n more conversions or results
   task automatic wait_ev(input bit res, input int n);
      int b;
      int k;
      b = res ? res_n : conv_n;
      for (k = 0; k < 9000 && (res ? res_n : conv_n) < b + n; k++) @(negedge clk_sys_i);
      if ((res ? res_n : conv_n) < b + n) begin
         err_count++;
         summarize();
      end
   endtask : wait_ev

   // ==========================================
   // converter model, notes each expected result
   always @(posedge clk_sys_i) begin
      cyc++;
      adc_valid_i <= conv_start_o;
      if (sensor_reset_o === 1'b1) rst_seen = 1'b1;
      if (conv_start_o === 1'b1) begin
         rnd = lfsr(rnd);
         adc_x_i <= rnd;
         adc_y_i <= ~rnd;
         adc_z_i <= {rnd[7:0], rnd[15:8]};
         sx += int'($signed(rnd));
         sy += int'($signed(~rnd));
         sz += int'($signed({rnd[7:0], rnd[15:8]}));
         period = cyc - last;
         last = cyc;
         conv_n++;
         cnt++;
         if (cnt == (16 << avg)) begin
            exp_q.push_back({res16(sx, off_x_i), res16(sy, off_y_i), res16(sz, off_z_i)});
            chk(48'(rst_seen), 48'(aut));
            {cnt, sx, sy, sz, rst_seen} = '0;
         end
      end
   end
   always @(negedge clk_sys_i) begin
      if (result_valid_o === 1'b1) begin
         res_n++;
         chk({result_x_o, result_y_o, result_z_o}, exp_q.size() ? exp_q.pop_front() : 48'hX);
      end
   end
   always @(posedge clk_link_i) rd_seen <= reg_rd_i;
   always @(negedge clk_link_i) if (rd_seen) chk(48'(reg_rdata_o), 48'(rd_q.pop_front()));

   // ==========================================
   // main sequence
   initial begin
      int i;
      int j;
      int n0;
      repeat (20) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      repeat (6) @(posedge clk_link_i);
      rdx(8'h10, 8'h00);
      rdx(8'h11, 8'h00);
      rdx(8'h20, 8'h00);
      wrx(8'h11, 8'h10);
      rdx(8'h11, 8'h10);
      for (i = 0; i < 200 && sensor_reset_o !== 1'b0; i++) @(posedge clk_link_i);
      // busy flag reaches the read image a few cycles later
      repeat (8) @(posedge clk_link_i);
      rdx(8'h11, 8'h00);
      for (i = 0; i < 2; i++) begin
         wrx(8'h10, {5'h00, i[0], 2'b00});
         chk(48'(burst_skip_low_bytes_o), 48'(i[0]));
         for (j = 0; j < 7; j++) rdx(j[7:0], 8'h00);
      end
      for (i = 0; i < 8; i++) begin
         cnt = 0;
         wrx(8'h10, {i[2:0], 5'h01});
         wait_ev(1'b0, 2);
         chk(48'(period), 48'(CF << ((i < 4) ? i : 4)));
         wrx(8'h10, {i[2:0], 5'h00});
      end
      for (i = 0; i < 4; i++) begin
         {aut, byp} = i[1:0];
         avg = i[1:0];
         {cnt, sx, sy, sz, rst_seen} = '0;
         @(posedge clk_sys_i);
         off_x_i <= {rnd[14:0], 1'b0};
         off_y_i <= {~rnd[15:1], 1'b0};
         off_z_i <= {rnd[9:0], 6'h00};
         wrx(8'h11, {aut, 1'b0, byp, 5'h00});
         rdx(8'h11, {2'b00, byp, 5'h00});
         wrx(8'h10, {3'h0, avg, 3'b010});
         wait_ev(1'b1, 1);
         n0 = conv_n;
         repeat (200) @(posedge clk_sys_i);
         chk(48'(conv_n), 48'(n0));
         rdx(8'h10, {3'h0, avg, 3'b000});
      end
      avg = 2'h1;
      cnt = 0;
      wrx(8'h10, 8'h09);
      wait_ev(1'b1, 2);
      wrx(8'h10, 8'h08);
      summarize();
   end
endmodule : magnetometer_measurement_control_tb
`default_nettype wire
